// File: src/jbuf_defines.vh
// Offsets, field positions, loop codes, reset values and response codes of the jitter buffer block.
`ifndef JBUF_DEFINES_VH
`define JBUF_DEFINES_VH
`define OFF_CTRL 8'h00
`define OFF_UDP_PORT 8'h04
`define OFF_STATUS 8'h08
`define OFF_OVF_COUNT 8'h0C
`define OFF_UNF_COUNT 8'h10
`define OFF_FILL 8'h14
`define CTRL_LOOP_LSB 0
`define CTRL_LOOP_MSB 1
`define LOOP_DISABLED 2'h0
`define LOOP_INTERNAL 2'h1
`define LOOP_EXTERNAL 2'h2
`define UDP_PORT_RESET 16'h085E
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: src/jbuf_mem.v
// Storage array of the jitter buffer with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module jbuf_mem #(
  parameter WIDTH = 8,
  parameter AW = 4
) (
  // Clock.
  input wire clk,
  // Write port.
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port.
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // jbuf_mem
`default_nettype wire

// File: src/skid2.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module skid2 #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] d0_r;
  reg [WIDTH-1:0] d1_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = d0_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (srst) begin
      cnt_r <= 2'd0;
      d0_r <= {WIDTH{1'b0}};
      d1_r <= {WIDTH{1'b0}};
    end else begin
      if (pop) begin
        d0_r <= d1_r;
      end
      if (push) begin
        if ((cnt_r == 2'd0) || (cnt_r == 2'd1 && pop)) begin
          d0_r <= in_data;
        end else begin
          d1_r <= in_data;
        end
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // skid2
`default_nettype wire

// File: src/tdm_jitter_loop.v
// Jitter buffer with overflow flush, event counters and loopback steering for one channel.
//
// Notes on behaviour
// - Each overflow event bumps a readable overflow counter until it reaches full scale.
// - Playout starts only once the buffer reaches half full, leaving equal headroom.
// - Packet words that arrive with the buffer full are dropped and flagged as overflow.
// - An overflow empties the buffer at once and raises a forced underflow with it.
// - After the flush the buffer refills from empty to the midpoint before playout.
// - The forced underflow is also counted, so true underflows are the difference.
// - A writable UDP destination port is carried on outgoing packets, default 2142.
// - A loopback state selects internal, external or disabled; disabled ends looping.
// - External loop returns TDM receive data to the port and still sends it onward.
// - Internal loop returns network data to the network and still plays it out.
// - A line loopback command from the facility data link forces external loop.
`timescale 1ns/100ps
`default_nettype none
`include "jbuf_defines.vh"
module tdm_jitter_loop #(
  parameter WIDTH = 8,
  parameter AW = 4,
  parameter CW = 16
) (
  // Clock and reset.
  input wire CLK,
  input wire SRST,
  // AXI4-Lite write address and data.
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // AXI4-Lite write response.
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read.
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Packet side receive words into the buffer.
  input wire [WIDTH-1:0] NET_RX_DATA,
  input wire NET_RX_VALID,
  // TDM side playout request and data.
  input wire TDM_TX_TICK,
  output reg [WIDTH-1:0] TDM_TX_DATA,
  output reg TDM_TX_VALID,
  // TDM receive words, toward network.
  input wire [WIDTH-1:0] TDM_RX_DATA,
  input wire TDM_RX_VALID,
  output reg [WIDTH-1:0] TDM_LOOP_DATA,
  output reg TDM_LOOP_VALID,
  // Toward packet network through two-entry buffer.
  output reg [WIDTH-1:0] NET_TX_DATA,
  output reg NET_TX_VALID,
  input wire NET_TX_READY,
  output reg [15:0] NET_TX_UDP_PORT,
  // Facility data link line loopback command.
  input wire FDL_LINE_LOOP,
  // Status.
  output reg OVERFLOW_PULSE,
  output reg UNDERFLOW_PULSE
);
  // Full is 2**AW entries and the midpoint half of that, built at the width of the fill count.
  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
  localparam [AW:0] MID = {2'b01, {(AW-1){1'b0}}};
  // Flush lasts one cycle: the word streaming in during that cycle is dropped, not recounted.
  localparam ST_FILL = 2'd0;
  localparam ST_PLAY = 2'd1;
  localparam ST_FLUSH = 2'd2;

  reg [1:0] loop_r;
  reg fdl_loop_r;
  reg fdl_prev_r;
  reg [15:0] udp_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [AW:0] fill_r;
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [CW-1:0] ovf_cnt_r;
  reg [CW-1:0] unf_cnt_r;
  reg rd_pend_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire [WIDTH-1:0] mem_q;
  wire [1:0] loop_eff;
  wire wr_ok;
  wire ovf_evt;
  wire starve;
  wire unf_evt;
  wire rd_ok;
  wire src_valid;
  wire [WIDTH-1:0] src_data;
  wire dis_wr;
  wire skid_valid;
  wire [WIDTH-1:0] skid_data;
  wire skid_take;

  // Command from the line wins over a disabled setting.
  assign loop_eff = fdl_loop_r ? `LOOP_EXTERNAL : loop_r;

  // A write of the disabled value ends a loop forced from the line as well; the command
  // must drop and rise again to re-arm it.
  assign dis_wr = aw_got_r && w_got_r && w_strb_r[0]
    && ({aw_addr_r[7:2], 2'b00} == `OFF_CTRL)
    && (w_data_r[`CTRL_LOOP_MSB:`CTRL_LOOP_LSB] == `LOOP_DISABLED);

  assign wr_ok = NET_RX_VALID && (fill_r != FULL) && (st_r != ST_FLUSH);
  // Only the first full hit counts; the flush state swallows the rest.
  assign ovf_evt = NET_RX_VALID && (fill_r == FULL) && (st_r != ST_FLUSH);
  // An empty buffer at a playout request is a genuine underflow and sends it back to filling.
  assign starve = TDM_TX_TICK && (st_r == ST_PLAY) && (fill_r == {(AW+1){1'b0}});
  assign unf_evt = ovf_evt || starve;
  assign rd_ok = TDM_TX_TICK && (st_r == ST_PLAY) && (fill_r != {(AW+1){1'b0}});

  jbuf_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (
    .clk(CLK),
    .wr_en(wr_ok),
    .wr_addr(wp_r),
    .wr_data(NET_RX_DATA),
    .rd_en(rd_ok),
    .rd_addr(rp_r),
    .rd_data(mem_q)
  );

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_FILL: begin
        if (ovf_evt) begin
          st_nxt = ST_FLUSH;
        end else if (fill_r + {{AW{1'b0}}, wr_ok} >= MID) begin
          st_nxt = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (ovf_evt) begin
          st_nxt = ST_FLUSH;
        end else if (starve) begin
          st_nxt = ST_FILL;
        end
      end
      ST_FLUSH: begin
        st_nxt = ST_FILL;
      end
      default: begin
        st_nxt = ST_FILL;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      st_r <= ST_FILL;
      fill_r <= {(AW+1){1'b0}};
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      ovf_cnt_r <= {CW{1'b0}};
      unf_cnt_r <= {CW{1'b0}};
      rd_pend_r <= 1'b0;
      OVERFLOW_PULSE <= 1'b0;
      UNDERFLOW_PULSE <= 1'b0;
      TDM_TX_DATA <= {WIDTH{1'b0}};
      TDM_TX_VALID <= 1'b0;
      fdl_loop_r <= 1'b0;
      fdl_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // Only a rising command arms the loop, so a disable write sticks while it stays high.
      fdl_prev_r <= FDL_LINE_LOOP;
      fdl_loop_r <= FDL_LINE_LOOP && (fdl_loop_r || !fdl_prev_r) && !dis_wr;
      OVERFLOW_PULSE <= ovf_evt;
      UNDERFLOW_PULSE <= unf_evt;
      if (ovf_evt) begin
        // Flush drops everything held, empties the buffer in one step.
        fill_r <= {(AW+1){1'b0}};
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
      end else begin
        fill_r <= fill_r + {{AW{1'b0}}, wr_ok} - {{AW{1'b0}}, rd_ok};
        if (wr_ok) begin
          wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
        end
        if (rd_ok) begin
          rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      // Counters stop at full scale; a wrapped count would read as fewer events than happened.
      if (ovf_evt && ovf_cnt_r != {CW{1'b1}}) begin
        ovf_cnt_r <= ovf_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      if (unf_evt && unf_cnt_r != {CW{1'b1}}) begin
        unf_cnt_r <= unf_cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      rd_pend_r <= rd_ok && !ovf_evt;
      TDM_TX_VALID <= rd_pend_r;
      if (rd_pend_r) begin
        TDM_TX_DATA <= mem_q;
      end
    end
  end

  // External loop returns line data to the line.
  always @(posedge CLK) begin
    if (SRST) begin
      TDM_LOOP_DATA <= {WIDTH{1'b0}};
      TDM_LOOP_VALID <= 1'b0;
    end else begin
      TDM_LOOP_VALID <= TDM_RX_VALID && (loop_eff == `LOOP_EXTERNAL);
      TDM_LOOP_DATA <= TDM_RX_DATA;
    end
  end

  // Internal loop returns network words to the network; else line words go onward.
  assign src_valid = (loop_eff == `LOOP_INTERNAL) ? rd_pend_r : TDM_RX_VALID;
  assign src_data = (loop_eff == `LOOP_INTERNAL) ? mem_q : TDM_RX_DATA;
  assign skid_take = skid_valid && (!NET_TX_VALID || NET_TX_READY);

  // Words that arrive while both entries are full are lost; the line side cannot stall.
  skid2 #(.WIDTH(WIDTH)) u_skid (
    .clk(CLK),
    .srst(SRST),
    .in_valid(src_valid),
    .in_ready(),
    .in_data(src_data),
    .out_valid(skid_valid),
    .out_ready(!NET_TX_VALID || NET_TX_READY),
    .out_data(skid_data)
  );

  always @(posedge CLK) begin
    if (SRST) begin
      NET_TX_VALID <= 1'b0;
      NET_TX_DATA <= {WIDTH{1'b0}};
      NET_TX_UDP_PORT <= `UDP_PORT_RESET;
    end else begin
      NET_TX_UDP_PORT <= udp_r;
      if (skid_take) begin
        NET_TX_VALID <= 1'b1;
        NET_TX_DATA <= skid_data;
      end else if (NET_TX_READY) begin
        NET_TX_VALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order, then one response.
  always @(posedge CLK) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      loop_r <= `LOOP_DISABLED;
      udp_r <= `UDP_PORT_RESET;
    end else begin
      S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `RESP_OKAY;
        case ({aw_addr_r[7:2], 2'b00})
          `OFF_CTRL: begin
            if (w_strb_r[0]) begin
              loop_r <= w_data_r[`CTRL_LOOP_MSB:`CTRL_LOOP_LSB];
            end
          end
          `OFF_UDP_PORT: begin
            if (w_strb_r[0]) begin
              udp_r[7:0] <= w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
              udp_r[15:8] <= w_data_r[15:8];
            end
          end
          `OFF_STATUS, `OFF_OVF_COUNT, `OFF_UNF_COUNT, `OFF_FILL: begin
            S_AXI_BRESP <= `RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP <= `RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read.
  always @(posedge CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `RESP_OKAY;
        // Unused upper bits read as zero.
        S_AXI_RDATA <= 32'h0000_0000;
        case ({S_AXI_ARADDR[7:2], 2'b00})
          `OFF_CTRL: S_AXI_RDATA[1:0] <= loop_r;
          `OFF_UDP_PORT: S_AXI_RDATA[15:0] <= udp_r;
          `OFF_STATUS: S_AXI_RDATA[4:0] <= {fdl_loop_r, loop_eff, st_r};
          `OFF_OVF_COUNT: S_AXI_RDATA[CW-1:0] <= ovf_cnt_r;
          `OFF_UNF_COUNT: S_AXI_RDATA[CW-1:0] <= unf_cnt_r;
          `OFF_FILL: S_AXI_RDATA[AW:0] <= fill_r;
          default: S_AXI_RRESP <= `RESP_SLVERR;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // tdm_jitter_loop
`default_nettype wire

// File: tb/net_far_end.sv
// Packet network sink model that accepts words with optional random stalls.
`timescale 1ns/100ps
`default_nettype none
module net_far_end (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Stall mode and acceptance.
  input wire logic slow,
  output logic ready
);
  // The far end runs the same framing as this end, so it only paces acceptance.
  always @(posedge clk) begin
    ready <= !srst && (!slow || $urandom_range(0, 1) == 1);
  end
endmodule // net_far_end
`default_nettype wire

// File: tb/tdm_jitter_loop_chk.sv
// Port checks of the jitter buffer and loopback block.
`timescale 1ns/100ps
`default_nettype none
module tdm_jitter_loop_chk #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Register read handshake.
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  // Data paths.
  input wire logic TDM_TX_TICK,
  input wire logic TDM_TX_VALID,
  input wire logic [WIDTH-1:0] TDM_RX_DATA,
  input wire logic TDM_RX_VALID,
  input wire logic [WIDTH-1:0] TDM_LOOP_DATA,
  input wire logic TDM_LOOP_VALID,
  input wire logic [WIDTH-1:0] NET_TX_DATA,
  input wire logic NET_TX_VALID,
  input wire logic NET_TX_READY,
  input wire logic [15:0] NET_TX_UDP_PORT,
  input wire logic FDL_LINE_LOOP,
  // Events.
  input wire logic OVERFLOW_PULSE,
  input wire logic UNDERFLOW_PULSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_ovf;
    OVERFLOW_PULSE;
  endsequence
  // The refill needs many writes, so neither playout nor a new overflow can come soon.
  sequence s_quiet;
    !OVERFLOW_PULSE && !TDM_TX_VALID;
  endsequence
  a_ovf_unf: assert property (s_ovf |-> UNDERFLOW_PULSE)
    else $error("overflow without underflow");
  a_ovf_refill: assert property (s_ovf |-> ##3 s_quiet [*5])
    else $error("activity before refill");
  a_play_delay: assert property (TDM_TX_VALID |-> $past(TDM_TX_TICK, 2))
    else $error("played word without tick");
  // A disable write may end the forced loop later, so only its first cycle is checked.
  a_fdl_echo: assert property ($past(FDL_LINE_LOOP) && !$past(FDL_LINE_LOOP, 2)
    && FDL_LINE_LOOP && TDM_RX_VALID
    |=> TDM_LOOP_VALID && TDM_LOOP_DATA == $past(TDM_RX_DATA))
    else $error("line loop did not echo");
  a_loop_cause: assert property (TDM_LOOP_VALID |-> $past(TDM_RX_VALID))
    else $error("echo without received word");
  a_tx_hold: assert property (NET_TX_VALID && !NET_TX_READY
    |=> NET_TX_VALID && $stable(NET_TX_DATA))
    else $error("network word dropped in stall");
  a_udp_reset: assert property ($past(SRST) |-> NET_TX_UDP_PORT == 16'h085E)
    else $error("port default wrong");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
endmodule // tdm_jitter_loop_chk
bind tdm_jitter_loop tdm_jitter_loop_chk #(.WIDTH(WIDTH)) chk_i (
  .CLK(CLK), .SRST(SRST),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .TDM_TX_TICK(TDM_TX_TICK), .TDM_TX_VALID(TDM_TX_VALID),
  .TDM_RX_DATA(TDM_RX_DATA), .TDM_RX_VALID(TDM_RX_VALID),
  .TDM_LOOP_DATA(TDM_LOOP_DATA), .TDM_LOOP_VALID(TDM_LOOP_VALID),
  .NET_TX_DATA(NET_TX_DATA), .NET_TX_VALID(NET_TX_VALID), .NET_TX_READY(NET_TX_READY),
  .NET_TX_UDP_PORT(NET_TX_UDP_PORT), .FDL_LINE_LOOP(FDL_LINE_LOOP),
  .OVERFLOW_PULSE(OVERFLOW_PULSE), .UNDERFLOW_PULSE(UNDERFLOW_PULSE)
);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the jitter buffer and loopback block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic CLK, SRST, slow;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] NET_RX_DATA, TDM_TX_DATA, TDM_RX_DATA, TDM_LOOP_DATA, NET_TX_DATA;
  logic NET_RX_VALID, TDM_TX_TICK, TDM_TX_VALID, TDM_RX_VALID, TDM_LOOP_VALID;
  logic NET_TX_VALID, NET_TX_READY, FDL_LINE_LOOP, OVERFLOW_PULSE, UNDERFLOW_PULSE;
  logic [15:0] NET_TX_UDP_PORT;
  logic [7:0] jb[$], netq[$], netx[$];
  logic [7:0] w;
  int err_total, cmp_count, st, ovf_n, unf_n, ovf_seen, unf_seen;

  tdm_jitter_loop uut (
    .CLK(CLK), .SRST(SRST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .NET_RX_DATA(NET_RX_DATA), .NET_RX_VALID(NET_RX_VALID),
    .TDM_TX_TICK(TDM_TX_TICK), .TDM_TX_DATA(TDM_TX_DATA), .TDM_TX_VALID(TDM_TX_VALID),
    .TDM_RX_DATA(TDM_RX_DATA), .TDM_RX_VALID(TDM_RX_VALID),
    .TDM_LOOP_DATA(TDM_LOOP_DATA), .TDM_LOOP_VALID(TDM_LOOP_VALID),
    .NET_TX_DATA(NET_TX_DATA), .NET_TX_VALID(NET_TX_VALID), .NET_TX_READY(NET_TX_READY),
    .NET_TX_UDP_PORT(NET_TX_UDP_PORT), .FDL_LINE_LOOP(FDL_LINE_LOOP),
    .OVERFLOW_PULSE(OVERFLOW_PULSE), .UNDERFLOW_PULSE(UNDERFLOW_PULSE)
  );
  net_far_end far (.clk(CLK), .srst(SRST), .slow(slow), .ready(NET_TX_READY));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (NET_TX_VALID && NET_TX_READY) netq.push_back(NET_TX_DATA);
    if (OVERFLOW_PULSE) ovf_seen++;
    if (UNDERFLOW_PULSE) unf_seen++;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task give_verdict;
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    chk(S_AXI_BRESP, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, d);
    chk(S_AXI_RRESP, e);
  endtask

  // Back-to-back packet words; the model empties itself on a write into a full buffer
  // and drops the word right after it, which lands in the one-cycle flush.
  task push(input int n);
    int fl;
    fl = 0;
    repeat (n) begin
      @(posedge CLK);
      w = $urandom;
      NET_RX_VALID <= 1'b1;
      NET_RX_DATA <= w;
      if (fl != 0) fl = 0;
      else if (jb.size() == 16) begin
        jb.delete();
        ovf_n++;
        unf_n++;
        st = 0;
        fl = 1;
      end else jb.push_back(w);
      if (jb.size() >= 8) st = 1;
    end
    @(posedge CLK);
    NET_RX_VALID <= 1'b0;
  endtask

  task tick(input logic lp);
    logic v;
    logic [7:0] d;
    v = 1'b0;
    d = 8'h00;
    @(posedge CLK);
    TDM_TX_TICK <= 1'b1;
    @(posedge CLK);
    TDM_TX_TICK <= 1'b0;
    repeat (4) begin
      @(posedge CLK);
      if (TDM_TX_VALID) begin
        v = 1'b1;
        d = TDM_TX_DATA;
      end
    end
    if (st == 1 && jb.size() > 0) begin
      chk({v, d}, {1'b1, jb[0]});
      if (lp) netx.push_back(jb[0]);
      void'(jb.pop_front());
    end else begin
      chk(v, 1'b0);
      if (st == 1) unf_n++;
      st = 0;
    end
  endtask

  task rx(input logic lp, input logic nx);
    @(posedge CLK);
    w = $urandom;
    TDM_RX_VALID <= 1'b1;
    TDM_RX_DATA <= w;
    @(posedge CLK);
    TDM_RX_VALID <= 1'b0;
    @(posedge CLK);
    chk(TDM_LOOP_VALID, lp);
    if (lp) chk(TDM_LOOP_DATA, w);
    if (nx) netx.push_back(w);
  endtask

  // The stalling far end must still receive every word, in order.
  task netchk;
    repeat (40) @(posedge CLK);
    chk(netq.size(), netx.size());
    while (netq.size() > 0 && netx.size() > 0) chk(netq.pop_front(), netx.pop_front());
    netq.delete();
    netx.delete();
  endtask

  initial begin
    repeat (5000) @(posedge CLK);
    err_total++;
    give_verdict;
  end

  initial begin
    SRST = 1'b1;
    slow = 1'b1;
    S_AXI_WSTRB = 4'hF;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    {NET_RX_DATA, NET_RX_VALID, TDM_TX_TICK, TDM_RX_DATA, TDM_RX_VALID, FDL_LINE_LOOP} = '0;
    void'($urandom(88));
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    chk(NET_TX_UDP_PORT, 16'h085E);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0000_085E, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h0C, 32'h5, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    wr(8'h04, 32'h1234, 2'h0);
    @(posedge CLK);
    chk(NET_TX_UDP_PORT, 16'h1234);
    push(7);
    rd(8'h08, 32'h0, 2'h0);
    push(1);
    rd(8'h08, 32'h1, 2'h0);
    rd(8'h14, 32'h8, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    rd(8'h08, 32'h5, 2'h0);
    repeat (3) tick(1'b1);
    rx(1'b0, 1'b0);
    netchk;
    wr(8'h00, 32'h0, 2'h0);
    push(13);
    rd(8'h0C, ovf_n, 2'h0);
    rd(8'h10, unf_n, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    tick(1'b0);
    push(8);
    repeat (9) tick(1'b0);
    rd(8'h10, unf_n, 2'h0);
    chk(ovf_seen, ovf_n);
    chk(unf_seen, unf_n);
    wr(8'h00, 32'h2, 2'h0);
    rx(1'b1, 1'b1);
    wr(8'h00, 32'h0, 2'h0);
    rx(1'b0, 1'b1);
    FDL_LINE_LOOP <= 1'b1;
    rx(1'b1, 1'b1);
    rd(8'h08, 32'h18, 2'h0);
    wr(8'h00, 32'h0000_0000, 2'h0);
    rx(1'b0, 1'b1);
    rd(8'h08, 32'h0000_0000, 2'h0);
    FDL_LINE_LOOP <= 1'b0;
    rx(1'b0, 1'b1);
    netchk;
    SRST <= 1'b1;
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rd(8'h0C, 32'h0000_0000, 2'h0);
    rd(8'h10, 32'h0000_0000, 2'h0);
    rd(8'h04, 32'h0000_085E, 2'h0);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
